// ==== hw/sec_setpw.sv ====
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sec_setpw_map.svh"
// Summary of operation
// - Command F1h requests one 512-byte parameter sector; its contents steer the command.
// - User password completion enables lock but device stays unlocked until reset.
// - Lock takes hold on link reset without preservation, or power-on, when enabled.
// - Word 0 bit 0 picks user (0) or master (1) password.
// - Word 0 bit 8 picks high (0) or maximum (1) security level.
// - All 32 password bytes in words 1-16 are stored and compared.
// - Revision code in word 17 stored only when master password selected.
// - Stored master revision code is reported as identification word 92.
// - Master revision code defaults to FFFEh until a master password sets it.
// - Codes 0000h and FFFFh are reserved and refused when master password selected.
// - User selection replaces stored user password and arms lock for next power-on.
// - User at high level: user or stored master password may unlock.
// - User at maximum level: only user password unlocks; master kept but refused.
// - Maximum level without user password: only erase sequence leaves locked state.
// - Master selection stores master password and never enables the lock.
// - Completion reports only abort, ready, DSC and error bits; others read zero.
// - Frozen mode rejects the command with an aborted error.
module sec_setpw #(
  parameter int SECTOR_WORDS = 256
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [255:0] candPassword,
  input  wire logic         candIsMaster,
  output logic              unlockMatch,
  output logic              irq
);
  if (SECTOR_WORDS < 19 || SECTOR_WORDS > 512) begin : g_bad_size
    $error("SECTOR_WORDS must cover words 0 to 18 and fit the counter");
  end

  localparam logic [9:0] LAST_WORD = 10'(SECTOR_WORDS - 1);

  sec_setpw_pkg::cmdState_t state_reg;
  logic [9:0]   wordIdx_reg;
  logic [15:0]  ctlWord_reg;
  logic [255:0] pwBuf_reg;
  logic [15:0]  revBuf_reg;
  logic [255:0] userPw_reg;
  logic [255:0] masterPw_reg;
  logic [15:0]  revCode_reg;
  logic         levelMax_reg;
  logic         lockEn_reg;
  logic         locked_reg;
  logic         frozen_reg;
  logic [7:0]   status_reg;
  logic [7:0]   error_reg;
  logic [1:0]   intStat_reg;
  logic [1:0]   intMask_reg;
  logic         evDone;
  logic         evAbort;

  // AXI4-Lite write channel: address and data taken in either order
  logic         awHeld_reg;
  logic         wHeld_reg;
  logic [11:0]  awAddr_reg;
  logic [31:0]  wData_reg;
  logic [3:0]   wStrb_reg;
  logic         wrFire;
  logic         wrOk;

  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign wrFire        = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign wrOk          = wStrb_reg[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 12'h000;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_reg > `OFS_INTMASK) ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wrCmd;
  logic wrData;
  logic wrCtrl;
  assign wrCmd  = wrFire && wrOk && awAddr_reg == `OFS_CMD;
  assign wrData = wrFire && wrOk && awAddr_reg == `OFS_DATA;
  assign wrCtrl = wrFire && wrOk && awAddr_reg == `OFS_CTRL;

  // Command sequencing
  logic rsvRev;
  logic isMaster;
  assign isMaster = ctlWord_reg[`W0_IDENT];
  assign rsvRev   = revBuf_reg == `REV_RSV_LO || revBuf_reg == `REV_RSV_HI;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= sec_setpw_pkg::IDLE;
      wordIdx_reg <= 10'd0;
      ctlWord_reg <= 16'h0000;
      pwBuf_reg   <= '0;
      revBuf_reg  <= 16'h0000;
    end else begin
      case (state_reg)
        sec_setpw_pkg::IDLE: begin
          if (wrCmd && wData_reg[7:0] == `CMD_SET_PW && !frozen_reg) begin
            state_reg   <= sec_setpw_pkg::XFER;
            wordIdx_reg <= 10'd0;
          end
        end
        sec_setpw_pkg::XFER: begin
          if (wrData) begin
            if (wordIdx_reg == 10'd0) begin
              ctlWord_reg <= wData_reg[15:0];
            end else if (wordIdx_reg <= {1'b0, `W_PW_LAST}) begin
              pwBuf_reg[(wordIdx_reg - 10'd1) * 16 +: 16] <= wData_reg[15:0];
            end else if (wordIdx_reg == {1'b0, `W_REV}) begin
              revBuf_reg <= wData_reg[15:0];
            end
            if (wordIdx_reg == LAST_WORD) begin
              state_reg <= sec_setpw_pkg::APPLY;
            end
            wordIdx_reg <= wordIdx_reg + 10'd1;
          end
        end
        sec_setpw_pkg::APPLY: begin
          state_reg <= sec_setpw_pkg::IDLE;
        end
        default: begin
          state_reg <= sec_setpw_pkg::IDLE;
        end
      endcase
    end
  end

  logic applyOk;
  logic applyBad;
  logic cmdReject;
  assign applyOk   = state_reg == sec_setpw_pkg::APPLY && !(isMaster && rsvRev);
  assign applyBad  = state_reg == sec_setpw_pkg::APPLY && isMaster && rsvRev;
  assign cmdReject = state_reg == sec_setpw_pkg::IDLE && wrCmd
                     && (wData_reg[7:0] != `CMD_SET_PW || frozen_reg);
  assign evDone    = applyOk;
  assign evAbort   = applyBad || cmdReject;

  // Password storage and level
  always_ff @(posedge clk) begin
    if (rst) begin
      userPw_reg   <= '0;
      masterPw_reg <= '0;
      levelMax_reg <= 1'b0;
      revCode_reg  <= `REV_DEFAULT;
    end else if (applyOk) begin
      if (isMaster) begin
        masterPw_reg <= pwBuf_reg;
        revCode_reg  <= revBuf_reg;
      end else begin
        userPw_reg   <= pwBuf_reg;
        levelMax_reg <= ctlWord_reg[`W0_LEVEL];
      end
    end
  end

  // Lock arming, reset events, freeze
  logic resetEvt;
  logic porEvt;
  assign porEvt   = wrCtrl && wData_reg[`CTRL_POR];
  assign resetEvt = porEvt || (wrCtrl && wData_reg[`CTRL_LINKRST] && wData_reg[`CTRL_NOPRES]);

  always_ff @(posedge clk) begin
    if (rst) begin
      lockEn_reg <= 1'b0;
    end else if (applyOk && !isMaster) begin
      lockEn_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      locked_reg <= 1'b0;
    end else if (resetEvt && lockEn_reg) begin
      locked_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frozen_reg <= 1'b0;
    end else if (wrCtrl && wData_reg[`CTRL_FREEZE]) begin
      frozen_reg <= 1'b1;
    end else if (porEvt) begin
      frozen_reg <= 1'b0;
    end
  end

  // Task file status and error
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= 8'h50;
      error_reg  <= 8'h00;
    end else if (evAbort) begin
      status_reg <= 8'h51;
      error_reg  <= 8'h04;
    end else if (evDone) begin
      status_reg <= 8'h50;
      error_reg  <= 8'h00;
    end else if (wrCmd) begin
      status_reg <= 8'h58;
      error_reg  <= 8'h00;
    end
  end

  // Later unlock check: maximum level refuses the master password
  always_ff @(posedge clk) begin
    if (rst) begin
      unlockMatch <= 1'b0;
    end else if (candIsMaster) begin
      unlockMatch <= !levelMax_reg && candPassword == masterPw_reg;
    end else begin
      unlockMatch <= lockEn_reg && candPassword == userPw_reg;
    end
  end

  // Interrupt status: read clears, a new event wins
  logic rdIntStat;
  always_ff @(posedge clk) begin
    if (rst) begin
      intStat_reg <= 2'b00;
    end else begin
      intStat_reg <= (rdIntStat ? 2'b00 : intStat_reg) | {evAbort, evDone};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      intMask_reg <= 2'b00;
    end else if (wrFire && wrOk && awAddr_reg == `OFS_INTMASK) begin
      intMask_reg <= wData_reg[1:0];
    end
  end

  assign irq = |(intStat_reg & intMask_reg);

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rdIntStat     = s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_INTSTAT;

  logic [31:0] rdMux;
  logic        rdBad;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdBad = 1'b0;
    if (s_axi_araddr == `OFS_STATUS) begin
      rdMux[7:0] = status_reg;
    end else if (s_axi_araddr == `OFS_ERROR) begin
      rdMux[7:0] = error_reg;
    end else if (s_axi_araddr == `OFS_SECSTATE) begin
      // Maximum level while locked: only the erase sequence can clear it
      rdMux[4:0] = {frozen_reg, locked_reg && levelMax_reg, levelMax_reg, locked_reg, lockEn_reg};
    end else if (s_axi_araddr == `OFS_IDW92) begin
      rdMux[15:0] = revCode_reg;
    end else if (s_axi_araddr == `OFS_INTSTAT) begin
      rdMux[1:0] = intStat_reg;
    end else if (s_axi_araddr == `OFS_INTMASK) begin
      rdMux[1:0] = intMask_reg;
    end else if (s_axi_araddr == `OFS_CMD || s_axi_araddr == `OFS_DATA || s_axi_araddr == `OFS_CTRL) begin
      rdMux = 32'h0000_0000;
    end else begin
      rdBad = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdBad ? 2'b10 : 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_start;
    state_reg == sec_setpw_pkg::IDLE && wrCmd && wData_reg[7:0] == `CMD_SET_PW && !frozen_reg;
  endsequence

  property p_drq_on_start;
    s_start |=> state_reg == sec_setpw_pkg::XFER && status_reg[`ST_DRQ] && wordIdx_reg == 10'd0;
  endproperty
  a_drq_on_start: assert property (p_drq_on_start) else $error("F1h did not open transfer");

  property p_frozen_abort;
    state_reg == sec_setpw_pkg::IDLE && wrCmd && frozen_reg
      |=> state_reg == sec_setpw_pkg::IDLE && error_reg[`ER_ABT] && status_reg[`ST_ERR];
  endproperty
  a_frozen_abort: assert property (p_frozen_abort) else $error("Frozen command not aborted");

  property p_user_arms;
    applyOk && !isMaster |=> lockEn_reg && userPw_reg == $past(pwBuf_reg) && locked_reg == $past(locked_reg);
  endproperty
  a_user_arms: assert property (p_user_arms) else $error("User password did not arm lock");

  property p_master_no_lock;
    applyOk && isMaster && !lockEn_reg |=> !lockEn_reg && masterPw_reg == $past(pwBuf_reg);
  endproperty
  a_master_no_lock: assert property (p_master_no_lock) else $error("Master set enabled lock");

  property p_lock_on_reset;
    resetEvt && lockEn_reg |=> locked_reg;
  endproperty
  a_lock_on_reset: assert property (p_lock_on_reset) else $error("Lock missed reset event");

  property p_no_lock_without_reset;
    !locked_reg && !resetEvt |=> !locked_reg;
  endproperty
  a_no_lock_without_reset: assert property (p_no_lock_without_reset) else $error("Locked early");

  property p_rev_user_kept;
    applyOk && !isMaster |=> $stable(revCode_reg);
  endproperty
  a_rev_user_kept: assert property (p_rev_user_kept) else $error("Revision changed by user");

  property p_rsv_abort;
    applyBad |=> error_reg == 8'h04 && status_reg == 8'h51 && $stable(masterPw_reg);
  endproperty
  a_rsv_abort: assert property (p_rsv_abort) else $error("Reserved revision accepted");

  property p_level_kept;
    applyOk && !isMaster |=> levelMax_reg == $past(ctlWord_reg[`W0_LEVEL]);
  endproperty
  a_level_kept: assert property (p_level_kept) else $error("Level not stored");

  property p_zero_bits;
    (status_reg & 8'hA6) == 8'h00 && (error_reg & 8'hFB) == 8'h00;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("Unused task file bit set");

  property p_max_refuses_master;
    candIsMaster && levelMax_reg |=> !unlockMatch;
  endproperty
  a_max_refuses_master: assert property (p_max_refuses_master) else $error("Master unlock at max");

endmodule : sec_setpw
`default_nettype wire

// ==== hw/sec_setpw_map.svh ====
`ifndef SEC_SETPW_MAP_SVH
`define SEC_SETPW_MAP_SVH
`define OFS_CMD      12'h000
`define OFS_DATA     12'h004
`define OFS_STATUS   12'h008
`define OFS_ERROR    12'h00C
`define OFS_CTRL     12'h010
`define OFS_SECSTATE 12'h014
`define OFS_IDW92    12'h018
`define OFS_INTSTAT  12'h01C
`define OFS_INTMASK  12'h020
`define CMD_SET_PW   8'hF1
`define ST_RDY       6
`define ST_DSC       4
`define ST_DRQ       3
`define ST_ERR       0
`define ER_ABT       2
`define W0_IDENT     0
`define W0_LEVEL     8
`define W_PW_FIRST   9'd1
`define W_PW_LAST    9'd16
`define W_REV        9'd17
`define REV_DEFAULT  16'hFFFE
`define REV_RSV_LO   16'h0000
`define REV_RSV_HI   16'hFFFF
`define CTRL_FREEZE  0
`define CTRL_LINKRST 1
`define CTRL_NOPRES  2
`define CTRL_POR     3
`define INT_DONE     0
`define INT_ABORT    1
`endif

// ==== hw/sec_setpw_pkg.sv ====
`default_nettype none
package sec_setpw_pkg;
  typedef enum logic [1:0] {
    IDLE,
    XFER,
    APPLY
  } cmdState_t;
endpackage : sec_setpw_pkg
`default_nettype wire

// ==== bench/sec_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sec_host_model (
  input  wire logic        clk,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  logic [1:0] lastBresp;

  initial begin
    lastBresp = 2'b00;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // Each channel drops at the edge that takes it; inverted payload exposes a late latch
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        aw = 1'b0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
        w = 1'b0;
      end
    end
    @(posedge clk);
    while (!s_axi_bvalid) begin
      @(posedge clk);
    end
    lastBresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (!s_axi_arready) begin
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    @(posedge clk);
    while (!s_axi_rvalid) begin
      @(posedge clk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : sec_host_model
`default_nettype wire

// ==== bench/test_security_set_password_cmd.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sec_setpw_map.svh"
module test_security_set_password_cmd;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rdWord;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rdResp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, unlockMatch, irq;
  logic [255:0] candPassword = '0;
  logic         candIsMaster = 1'b0;
  logic [255:0] masterPw, userPw;
  logic [15:0]  rev;
  int           num_errors = 0;
  int           total_checks = 0;
  int           cycles = 0;

  always #4 clk = ~clk;

  sec_host_model i_host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Short sector keeps the run brief
  sec_setpw #(.SECTOR_WORDS(19)) i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .candPassword, .candIsMaster, .unlockMatch, .irq);

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    i_host.rd(a, rdWord, rdResp);
    chk(n, e, rdWord);
  endtask : rchk

  function automatic logic [255:0] rnd256();
    logic [255:0] v;
    for (int k = 0; k < 8; k++) v[32*k +: 32] = $urandom;
    return v;
  endfunction : rnd256

  function automatic logic [15:0] ctrlWord(input logic m, input logic mx);
    return {7'h00, mx, 7'h00, m};
  endfunction : ctrlWord

  function automatic logic [31:0] expSec(input logic en, input logic lk, input logic mx, input logic fz);
    return {27'h0, fz, lk & mx, mx, lk, en};
  endfunction : expSec

  task automatic setpw(input logic [15:0] cw, input logic [255:0] pw, input logic [15:0] rv);
    logic [15:0] w;
    i_host.wr(`OFS_CMD, {24'h00_0000, `CMD_SET_PW});
    rchk("status_drq", `OFS_STATUS, 32'h0000_0058);
    for (int i = 0; i < 19; i++) begin
      w = (i == 0) ? cw : (i <= 16) ? pw[16*(i-1) +: 16] : (i == 17) ? rv : 16'($urandom);
      i_host.wr(`OFS_DATA, {16'h0000, w});
    end
  endtask : setpw

  task automatic finishCmd(input logic ab, input logic irqOn);
    rchk("status", `OFS_STATUS, ab ? 32'h0000_0051 : 32'h0000_0050);
    rchk("error", `OFS_ERROR, ab ? 32'h0000_0004 : 32'h0000_0000);
    @(negedge clk);
    chk("irq", {31'h0, irqOn}, {31'h0, irq});
    rchk("intstat", `OFS_INTSTAT, ab ? 32'h0000_0002 : 32'h0000_0001);
    @(negedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask : finishCmd

  task automatic um(input logic [255:0] pw, input logic m, input logic e);
    @(posedge clk);
    candPassword <= pw;
    candIsMaster <= m;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("unlock", {31'h0, e}, {31'h0, unlockMatch});
  endtask : um

  initial begin
    void'($urandom(82076));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk("status_rst", `OFS_STATUS, 32'h0000_0050);
    rchk("error_rst", `OFS_ERROR, 32'h0);
    rchk("rev_rst", `OFS_IDW92, {16'h0, `REV_DEFAULT});
    rchk("sec_rst", `OFS_SECSTATE, 32'h0);
    i_host.rd(12'h024, rdWord, rdResp);
    chk("rresp_unmapped", 32'h2, {30'h0, rdResp});
    i_host.wr(12'h024, 32'h0);
    chk("bresp_unmapped", 32'h2, {30'h0, i_host.lastBresp});
    i_host.wr(`OFS_INTMASK, 32'h3);
    chk("bresp_ok", 32'h0, {30'h0, i_host.lastBresp});
    rchk("intmask", `OFS_INTMASK, 32'h3);
    i_host.wr(`OFS_CMD, 32'h0000_00F2);
    finishCmd(1'b1, 1'b1);
    for (int i = 0; i < 2; i++) begin
      rev = 16'($urandom_range(16'hFFFE, 16'h0001));
      masterPw = rnd256();
      setpw(ctrlWord(1'b1, i[0]), masterPw, rev);
      finishCmd(1'b0, 1'b1);
      rchk("rev_master", `OFS_IDW92, {16'h0, rev});
      rchk("sec_master", `OFS_SECSTATE, 32'h0);
    end
    for (int i = 0; i < 2; i++) begin
      setpw(ctrlWord(1'b1, 1'b0), rnd256(), i[0] ? `REV_RSV_HI : `REV_RSV_LO);
      finishCmd(1'b1, 1'b1);
      rchk("rev_kept", `OFS_IDW92, {16'h0, rev});
    end
    userPw = rnd256();
    setpw(ctrlWord(1'b0, 1'b0), userPw, 16'($urandom));
    finishCmd(1'b0, 1'b1);
    rchk("rev_user", `OFS_IDW92, {16'h0, rev});
    rchk("sec_user_hi", `OFS_SECSTATE, expSec(1'b1, 1'b0, 1'b0, 1'b0));
    um(userPw, 1'b0, 1'b1);
    um(masterPw, 1'b1, 1'b1);
    um(userPw ^ {1'b1, 255'h0}, 1'b0, 1'b0);
    um(masterPw ^ 256'h1, 1'b1, 1'b0);
    userPw = rnd256();
    setpw(ctrlWord(1'b0, 1'b1), userPw, rev);
    finishCmd(1'b0, 1'b1);
    rchk("sec_user_max", `OFS_SECSTATE, expSec(1'b1, 1'b0, 1'b1, 1'b0));
    um(masterPw, 1'b1, 1'b0);
    um(userPw, 1'b0, 1'b1);
    i_host.wr(`OFS_CTRL, 32'h2);
    rchk("sec_preserve", `OFS_SECSTATE, expSec(1'b1, 1'b0, 1'b1, 1'b0));
    i_host.wr(`OFS_CTRL, 32'h6);
    rchk("sec_locked", `OFS_SECSTATE, expSec(1'b1, 1'b1, 1'b1, 1'b0));
    i_host.wr(`OFS_INTMASK, 32'h0);
    i_host.wr(`OFS_CTRL, 32'h1);
    rchk("sec_frozen", `OFS_SECSTATE, expSec(1'b1, 1'b1, 1'b1, 1'b1));
    i_host.wr(`OFS_CMD, {24'h00_0000, `CMD_SET_PW});
    finishCmd(1'b1, 1'b0);
    i_host.wr(`OFS_CTRL, 32'h8);
    rchk("sec_por", `OFS_SECSTATE, expSec(1'b1, 1'b1, 1'b1, 1'b0));
    summarize();
  end
endmodule : test_security_set_password_cmd
`default_nettype wire
